// ---- rtl/dbv_pkg.sv ----
// Purpose: shared constants and types for the display bias/cathode/temp bank
// Assumes: 8-bit register addresses and data from the serial port engine
// Notes: offsets are the printed register addresses
package dbv_pkg;

    localparam logic [7:0] DBV_OFS_BIAS = 8'h0e;
    localparam logic [7:0] DBV_OFS_GSENSE = 8'h0f;
    localparam logic [7:0] DBV_OFS_CMODE = 8'h10;
    localparam logic [7:0] DBV_OFS_CTIME = 8'h11;
    localparam logic [7:0] DBV_OFS_MAX_PIXEL_LEVEL = 8'h12;
    localparam logic [7:0] DBV_OFS_MCATH = 8'h13;
    localparam logic [7:0] DBV_OFS_IREF = 8'h14;
    localparam logic [7:0] DBV_OFS_DIM = 8'h15;
    localparam logic [7:0] DBV_OFS_TSLOPE = 8'h16;
    localparam logic [7:0] DBV_OFS_TOFF = 8'h17;
    localparam logic [7:0] DBV_OFS_TUPD = 8'h18;
    localparam logic [7:0] DBV_OFS_TREAD = 8'h19;

    // writable bit masks, undefined bits read zero
    localparam logic [7:0] DBV_MSK_BIAS = 8'h0f;
    localparam logic [7:0] DBV_MSK_GSENSE = 8'h1f;
    localparam logic [7:0] DBV_MSK_CMODE = 8'h0f;
    localparam logic [7:0] DBV_MSK_DIM = 8'h7f;
    localparam logic [7:0] DBV_MSK_TSLOPE = 8'h3f;
    localparam logic [7:0] DBV_MSK_FULL = 8'hff;

    localparam logic [7:0] DBV_RST_BIAS = 8'h01;
    localparam logic [7:0] DBV_RST_GSENSE = 8'h00;
    localparam logic [7:0] DBV_RST_CMODE = 8'h00;
    localparam logic [7:0] DBV_RST_CTIME = 8'h3d;
    localparam logic [7:0] DBV_RST_MAX_PIXEL_LEVEL = 8'h0d;
    localparam logic [7:0] DBV_RST_MCATH = 8'h51;
    localparam logic [7:0] DBV_RST_IREF = 8'h00;
    localparam logic [7:0] DBV_RST_DIM = 8'h01;
    localparam logic [7:0] DBV_RST_TSLOPE = 8'h13;
    localparam logic [7:0] DBV_RST_TOFF = 8'h35;
    localparam logic [7:0] DBV_RST_TUPD = 8'hff;

    // field positions
    localparam int DBV_BIT_EXTREF = 3;
    localparam int DBV_BIT_PUMPHOLD = 4;
    localparam int DBV_BIT_SHOLD = 3;
    localparam int DBV_BIT_SSBYP = 7;
    localparam logic [2:0] DBV_DUTY_BAD = 3'h7;
    localparam logic [2:0] DBV_DUTY_EVEN = 3'h3;
    localparam logic [1:0] DBV_ISEN_BAD = 2'h3;

    // converter clock: 25 MHz divided, full periods per frequency code
    localparam int DBV_CLK_HZ = 25000000;
    localparam int DBV_F0_HZ = 125000;
    localparam int DBV_F1_HZ = 250000;
    localparam int DBV_F2_HZ = 500000;
    localparam int DBV_F3_HZ = 800000;
    localparam logic [7:0] DBV_PER0 = 8'(DBV_CLK_HZ / DBV_F0_HZ);
    localparam logic [7:0] DBV_PER1 = 8'(DBV_CLK_HZ / DBV_F1_HZ);
    localparam logic [7:0] DBV_PER2 = 8'(DBV_CLK_HZ / DBV_F2_HZ);
    localparam logic [7:0] DBV_PER3 = 8'(DBV_CLK_HZ / DBV_F3_HZ);

    // soft-start base time 2 ms, doubled per code
    localparam int DBV_SS_BASE_MS = 2;
    localparam int DBV_SS_BASE_CYC = DBV_SS_BASE_MS * (DBV_CLK_HZ / 1000);

    typedef enum logic [1:0] {
        DBV_MODE_CURRENT = 2'b00,
        DBV_MODE_CLAMPED = 2'b01,
        DBV_MODE_MANUAL = 2'b10,
        DBV_MODE_RSVD = 2'b11
    } dbv_mode_t;

    typedef struct packed {
        logic external_reference_select;
        logic [2:0] pixel_sink_level;
        logic pump_hold_enable;
        logic gamma_sense_sample_hold_enable;
        logic [2:0] gamma_sense_current_step;
        logic [7:0] gamma_sense_current_div;
        logic converter_current_sensor_enable;
        dbv_mode_t cathode_regulation_mode;
        logic [7:0] max_pixel_level;
        logic [7:0] manual_cathode_level;
        logic [2:0] reference_current_coarse;
        logic [4:0] reference_current_fine;
        logic [6:0] dimming_level;
        logic [5:0] temp_slope_divider;
        logic [7:0] temp_offset_adjust;
    } dbv_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dbv_req_t;

endpackage

// ---- rtl/dbv_conv_clk.sv ----
// Purpose: cathode converter switching clock with duty and soft-start
// Assumes: timing byte held steady by the register bank
// Notes: hold input forces the switch low
`timescale 1ns/1ns
`default_nettype none
module dbv_conv_clk
    import dbv_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic hold,
    input wire logic [7:0] timing,
    output logic conv_clk,
    output logic soft_start_active
);
    logic [7:0] per_reg;
    logic [7:0] cnt_reg;
    logic [10:0] high_next;
    logic [24:0] ss_reg;
    logic [24:0] ss_len;

    // period from frequency field, high time from duty eighths
    always_comb begin
        unique case (timing[3:2])
            2'h0: per_reg = DBV_PER0;
            2'h1: per_reg = DBV_PER1;
            2'h2: per_reg = DBV_PER2;
            2'h3: per_reg = DBV_PER3;
        endcase
        high_next = (11'(per_reg) * (11'(timing[6:4]) + 11'h001)) >> 3;
        ss_len = 25'(DBV_SS_BASE_CYC) << timing[1:0];
    end

    // period counter
    always_ff @(posedge clk) begin
        if (srst || cnt_reg >= per_reg - 8'h01) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // soft-start runs on start unless bypassed
    always_ff @(posedge clk) begin
        if (srst) begin
            ss_reg <= '0;
        end else if (start && !timing[DBV_BIT_SSBYP]) begin
            ss_reg <= ss_len;
        end else if (ss_reg != '0) begin
            ss_reg <= ss_reg - 25'h1;
        end
    end

    // switch output; soft-start halves the duty
    always_ff @(posedge clk) begin
        if (srst) begin
            conv_clk <= 1'b0;
            soft_start_active <= 1'b0;
        end else begin
            soft_start_active <= (ss_reg != '0);
            if (hold) begin
                conv_clk <= 1'b0;
            end else if (ss_reg != '0) begin
                conv_clk <= ({3'h0, cnt_reg} < (high_next >> 1));
            end else begin
                conv_clk <= ({3'h0, cnt_reg} < high_next);
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/dbv_temp_upd.sv ----
// Purpose: frame counter that triggers temperature sampling
// Assumes: frame_start is a one-cycle pulse in clk domain
// Notes: sample pulse every interval+1 frames
`timescale 1ns/1ns
`default_nettype none
module dbv_temp_upd
    import dbv_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic frame_start,
    input wire logic [7:0] interval,
    output logic sample
);
    logic [7:0] cnt_reg;

    // count frames, pulse after interval+1 of them
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 8'h00;
            sample <= 1'b0;
        end else begin
            sample <= 1'b0;
            if (frame_start) begin
                if (cnt_reg >= interval) begin
                    cnt_reg <= 8'h00;
                    sample <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/dbv_regs.sv ----
// Purpose: bias, cathode converter and temperature config bank
// Assumes: serial port engine hands over decoded one-cycle requests
// Notes: video frame pulse and sensor value arrive from pins
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1: bit3 external reference, bits2-0 sink level
// R2: sink code zero off, seven maximum
// R3: pump hold stops converter during sampling
// R4: sample-hold enabled or bypassed on sense
// R5: step code n divides reference by 2^(7-n)
// R6: host waits 10 ms, samples in blanking
// R7: sensor field 00 off, 01/10 on
// R8: mode field selects current, clamped, manual
// R9: dimming only acts in current mode
// R10: timing bit7 bypasses soft-start
// R11: duty field sets converter high:low ratio
// R12: frequency field sets converter clock rate
// R13: soft-start duration 2,4,8,16 ms
// R14: max pixel level byte, reset 0d
// R15: manual cathode byte used in other modes
// R16: coarse plus fine reference current factor
// R17: dimming seven bits, reset 01
// R18: slope divider six bits, reset 13
// R19: temperature offset added to reading
// R20: reading refreshed every interval+1 frames
// R21: host writes interval 02 through ff only
// R22: written values stored and read back
// R23: reading digitised into read-only byte
// R24: undefined bits read zero, writes ignored
module dbv_regs
    import dbv_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire dbv_req_t req,
    input wire logic frame_start_pin,
    input wire logic [7:0] sensor_raw_pin,
    input wire logic conv_start,
    input wire logic sense_sampling,
    output logic [7:0] rdata,
    output logic rvalid,
    output dbv_cfg_t cfg,
    output logic [7:0] effective_dimming,
    output logic [7:0] temp_reading,
    output logic converter_switch,
    output logic soft_start_active
);
    logic [7:0] bias_reg;
    logic [7:0] gsense_reg;
    logic [7:0] cmode_reg;
    logic [7:0] ctime_reg;
    logic [7:0] max_pixel_level_reg;
    logic [7:0] mcath_reg;
    logic [7:0] iref_reg;
    logic [7:0] dim_reg;
    logic [7:0] tslope_reg;
    logic [7:0] toff_reg;
    logic [7:0] tupd_reg;
    logic [7:0] tread_reg;
    logic [1:0] frame_sync;
    logic frame_d;
    logic [7:0] sensor_s1;
    logic [7:0] sensor_s2;
    logic [7:0] sensor_s3;
    logic [7:0] sensor_ok;
    logic [7:0] rdata_next;
    logic temp_sample;
    logic conv_clk_w;
    logic ss_active_w;
    logic [8:0] temp_sum;
    logic [13:0] temp_scaled;
    logic [7:0] ctime_next;

    // assertions below share this clock and reset
    default clocking dbv_cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // masked write data for a given field mask
    function automatic logic [7:0] dbv_wr(input logic [7:0] d,
                                          input logic [7:0] m);
        dbv_wr = d & m;
    endfunction

    // write strobe for a given offset
    function automatic logic dbv_hit(input dbv_req_t r, input logic [7:0] a);
        dbv_hit = r.wr && (r.addr == a);
    endfunction

    // R11: reserved duty code falls back to even duty
    always_comb begin
        ctime_next = req.wdata;
        if (req.wdata[6:4] == DBV_DUTY_BAD) begin
            ctime_next[6:4] = DBV_DUTY_EVEN;
        end
    end

    // R22: store writes per register
    // R24: undefined bits masked on write
    always_ff @(posedge clk) begin
        if (srst) begin
            bias_reg <= DBV_RST_BIAS;
            gsense_reg <= DBV_RST_GSENSE;
            cmode_reg <= DBV_RST_CMODE;
            ctime_reg <= DBV_RST_CTIME;
            max_pixel_level_reg <= DBV_RST_MAX_PIXEL_LEVEL;
            mcath_reg <= DBV_RST_MCATH;
            iref_reg <= DBV_RST_IREF;
            dim_reg <= DBV_RST_DIM;
            tslope_reg <= DBV_RST_TSLOPE;
            toff_reg <= DBV_RST_TOFF;
            tupd_reg <= DBV_RST_TUPD;
        end else begin
            if (dbv_hit(req, DBV_OFS_BIAS)) begin
                bias_reg <= dbv_wr(req.wdata, DBV_MSK_BIAS);
            end
            if (dbv_hit(req, DBV_OFS_GSENSE)) begin
                gsense_reg <= dbv_wr(req.wdata, DBV_MSK_GSENSE);
            end
            if (dbv_hit(req, DBV_OFS_CMODE)) begin
                cmode_reg <= dbv_wr(req.wdata, DBV_MSK_CMODE);
            end
            if (dbv_hit(req, DBV_OFS_CTIME)) begin
                ctime_reg <= ctime_next;
            end
            if (dbv_hit(req, DBV_OFS_MAX_PIXEL_LEVEL)) begin
                max_pixel_level_reg <= req.wdata;
            end
            if (dbv_hit(req, DBV_OFS_MCATH)) begin
                mcath_reg <= req.wdata;
            end
            if (dbv_hit(req, DBV_OFS_IREF)) begin
                iref_reg <= req.wdata;
            end
            if (dbv_hit(req, DBV_OFS_DIM)) begin
                dim_reg <= dbv_wr(req.wdata, DBV_MSK_DIM);
            end
            if (dbv_hit(req, DBV_OFS_TSLOPE)) begin
                tslope_reg <= dbv_wr(req.wdata, DBV_MSK_TSLOPE);
            end
            if (dbv_hit(req, DBV_OFS_TOFF)) begin
                toff_reg <= req.wdata;
            end
            // R21: host keeps interval in range, stored as given
            if (dbv_hit(req, DBV_OFS_TUPD)) begin
                tupd_reg <= req.wdata;
            end
        end
    end

    // R22: read mux, unmapped reads zero
    always_comb begin
        unique case (req.addr)
            DBV_OFS_BIAS: rdata_next = bias_reg;
            DBV_OFS_GSENSE: rdata_next = gsense_reg;
            DBV_OFS_CMODE: rdata_next = cmode_reg;
            DBV_OFS_CTIME: rdata_next = ctime_reg;
            DBV_OFS_MAX_PIXEL_LEVEL: rdata_next = max_pixel_level_reg;
            DBV_OFS_MCATH: rdata_next = mcath_reg;
            DBV_OFS_IREF: rdata_next = iref_reg;
            DBV_OFS_DIM: rdata_next = dim_reg;
            DBV_OFS_TSLOPE: rdata_next = tslope_reg;
            DBV_OFS_TOFF: rdata_next = toff_reg;
            DBV_OFS_TUPD: rdata_next = tupd_reg;
            DBV_OFS_TREAD: rdata_next = tread_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // read answer one cycle after request
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= rdata_next;
            end
        end
    end

    // pin synchronisers, edge detect on second stage only
    // sensor word taken only once two samples agree, so no torn bits
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_sync <= 2'b00;
            frame_d <= 1'b0;
            sensor_s1 <= 8'h00;
            sensor_s2 <= 8'h00;
            sensor_s3 <= 8'h00;
            sensor_ok <= 8'h00;
        end else begin
            frame_sync <= {frame_sync[0], frame_start_pin};
            frame_d <= frame_sync[1];
            sensor_s1 <= sensor_raw_pin;
            sensor_s2 <= sensor_s1;
            sensor_s3 <= sensor_s2;
            if (sensor_s2 == sensor_s3) begin
                sensor_ok <= sensor_s2;
            end
        end
    end

    // R20: frame counter for refresh interval
    dbv_temp_upd u_temp_upd (
        .clk(clk),
        .srst(srst),
        .frame_start(frame_sync[1] && !frame_d),
        .interval(tupd_reg),
        .sample(temp_sample)
    );

    // R18: slope gain, R19: offset, saturate at ff
    always_comb begin
        temp_scaled = (14'(sensor_ok) * 14'(tslope_reg[5:0])) >> 5;
        temp_sum = {1'b0, temp_scaled[7:0]} + {1'b0, toff_reg};
        if (temp_scaled[13:8] != 6'h00 || temp_sum[8]) begin
            temp_sum = 9'h0ff;
        end
    end

    // R23: capture reading at each refresh
    always_ff @(posedge clk) begin
        if (srst) begin
            tread_reg <= 8'h00;
        end else if (temp_sample) begin
            tread_reg <= temp_sum[7:0];
        end
    end

    // R10: R12: R13: converter clock generator
    dbv_conv_clk u_conv_clk (
        .clk(clk),
        .srst(srst),
        .start(conv_start),
        // R3: pump hold during sense sampling
        .hold(gsense_reg[DBV_BIT_PUMPHOLD] && sense_sampling),
        .timing(ctime_reg),
        .conv_clk(conv_clk_w),
        .soft_start_active(ss_active_w)
    );

    // decoded configuration to analog blocks
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg <= '0;
            effective_dimming <= 8'h00;
            temp_reading <= 8'h00;
            converter_switch <= 1'b0;
            soft_start_active <= 1'b0;
        end else begin
            // R1: R2: reference select and sink level
            cfg.external_reference_select <= bias_reg[DBV_BIT_EXTREF];
            cfg.pixel_sink_level <= bias_reg[2:0];
            // R3: R4: pump hold and sample-hold enables
            cfg.pump_hold_enable <= gsense_reg[DBV_BIT_PUMPHOLD];
            cfg.gamma_sense_sample_hold_enable <= gsense_reg[DBV_BIT_SHOLD];
            // R5: step as divide-by 2^(7-n)
            cfg.gamma_sense_current_step <= gsense_reg[2:0];
            cfg.gamma_sense_current_div <= 8'h01 << (3'h7 - gsense_reg[2:0]);
            // R7: sensor on for 01 or 10 only
            cfg.converter_current_sensor_enable <=
                (cmode_reg[3:2] != 2'b00) && (cmode_reg[3:2] != DBV_ISEN_BAD);
            // R8: regulation mode
            cfg.cathode_regulation_mode <= dbv_mode_t'(cmode_reg[1:0]);
            // R14: R15: levels
            cfg.max_pixel_level <= max_pixel_level_reg;
            cfg.manual_cathode_level <= mcath_reg;
            // R16: coarse and fine current factors
            cfg.reference_current_coarse <= iref_reg[7:5];
            cfg.reference_current_fine <= iref_reg[4:0];
            // R17: R18: R19: dimming, slope and offset fields
            cfg.dimming_level <= dim_reg[6:0];
            cfg.temp_slope_divider <= tslope_reg[5:0];
            cfg.temp_offset_adjust <= toff_reg;
            // R9: dimming passes only in current mode
            effective_dimming <= (cmode_reg[1:0] == DBV_MODE_CURRENT) ?
                {1'b0, dim_reg[6:0]} : 8'h00;
            temp_reading <= tread_reg;
            converter_switch <= conv_clk_w;
            soft_start_active <= ss_active_w;
        end
    end

    // R6: sample-hold freezes sense output outside blanking
    // (host side timing, nothing enforced here)

    // R22: read returns stored value
    a_write_readback: assert property ( // R22
        req.rd && req.addr == DBV_OFS_MAX_PIXEL_LEVEL
        |=> rvalid && rdata == $past(max_pixel_level_reg))
        else $error("readback differs from stored value");
    // R22: every read answered next cycle
    a_read_answer: assert property ( // R22
        req.rd |=> rvalid)
        else $error("read not answered");
    // R24: undefined bits of dimming stay zero
    a_dim_reserved_zero: assert property ( // R24
        dim_reg[7] == 1'b0)
        else $error("dimming reserved bit set");
    // R24: reads outside the bank return zero
    a_unmapped_zero: assert property ( // R24
        req.rd && (req.addr < DBV_OFS_BIAS || req.addr > DBV_OFS_TREAD)
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    // R9: dimming masked outside current mode
    a_dim_mode_gate: assert property ( // R9
        cmode_reg[1:0] != 2'b00 |=> effective_dimming == 8'h00)
        else $error("dimming active in non-current mode");
    // R3: hold keeps switch low
    a_pump_hold_low: assert property ( // R3
        gsense_reg[4] && sense_sampling ##1 gsense_reg[4] && sense_sampling
        |=> !converter_switch)
        else $error("converter switching during hold");
    // R7: sensor off for 00 and 11
    a_sensor_decode: assert property ( // R7
        cmode_reg[3:2] == 2'b00 || cmode_reg[3:2] == 2'b11
        |=> !cfg.converter_current_sensor_enable)
        else $error("current sensor enabled on bad code");
    // R11: reserved duty never stored
    a_duty_legal: assert property ( // R11
        ctime_reg[6:4] != 3'h7)
        else $error("reserved duty code stored");
    // R23: reading only changes on refresh
    a_reading_stable: assert property ( // R23
        !temp_sample |=> $stable(tread_reg))
        else $error("reading changed outside refresh");
    // R5: divider matches step code 0
    a_step_divider: assert property ( // R5
        gsense_reg[2:0] == 3'h0 ##1 gsense_reg[2:0] == 3'h0
        |-> cfg.gamma_sense_current_div == 8'h80)
        else $error("step divider wrong for code 0");
    // R1: reference select follows bit 3
    a_ext_ref: assert property ( // R1
        1'b1 |=> cfg.external_reference_select == $past(bias_reg[3]))
        else $error("reference select mismatch");
    // R10: unbypassed start shows soft-start three cycles on
    a_soft_start_run: assert property ( // R10
        conv_start && !ctime_reg[DBV_BIT_SSBYP] |=> ##2 soft_start_active)
        else $error("soft-start did not run");

    c_temp_refresh: cover property (temp_sample);
    c_manual_mode: cover property (
        cfg.cathode_regulation_mode == DBV_MODE_MANUAL);
    c_clamped_mode: cover property (
        cfg.cathode_regulation_mode == DBV_MODE_CLAMPED);
    c_soft_start: cover property (soft_start_active);
endmodule
`default_nettype wire

// ---- verif/dbv_host.sv ----
// Purpose: host model issuing register requests to the bank
// Assumes: one request per cycle, changed 1 ns after the clock edge
// Notes: read data is taken in the cycle that rvalid stands
`timescale 1ns/1ns
`default_nettype none
module dbv_host
    import dbv_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output dbv_req_t req
);
    initial req = '0;

    // sense output never sampled here, so no settle wait is kept

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk) #1;
        req = '0;
    endtask

    // read, answer stands from the taking edge, read 1 ns after it
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk) #1;
        req = '0;
        d = (rvalid === 1'b1) ? rdata : 8'hxx; // missing answer fails
    endtask
endmodule
`default_nettype wire

// ---- verif/dbv_regs_tb.sv ----
// Purpose: self-checking bench for the bias, converter and temp bank
// Assumes: 25 MHz clock, host model drives the request port
// Notes: converter checks use the slowest clock code
`timescale 1ns/1ns
`default_nettype none
module dbv_regs_tb;
    import dbv_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic frame_start_pin = 1'b0;
    logic [7:0] sensor_raw_pin = 8'h40;
    logic conv_start = 1'b0;
    logic sense_sampling = 1'b0;
    dbv_req_t req;
    dbv_cfg_t cfg;
    logic [7:0] rdata, effective_dimming, temp_reading;
    logic rvalid, converter_switch, soft_start_active;
    int miscompares = 0;
    int compares = 0;
    logic [7:0] rstv [11] = '{8'h01, 8'h00, 8'h00, 8'h3d, 8'h0d, 8'h51,
        8'h00, 8'h01, 8'h13, 8'h35, 8'hff};
    logic [7:0] expv [11] = '{8'h0f, 8'h1f, 8'h06, 8'hbf, 8'hff, 8'hff,
        8'hff, 8'h7f, 8'h3f, 8'hff, 8'hff};

    always #20 clk = ~clk;

    dbv_host i_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));

    dbv_regs i_dut (.clk(clk), .srst(srst), .req(req),
        .frame_start_pin(frame_start_pin), .sensor_raw_pin(sensor_raw_pin),
        .conv_start(conv_start), .sense_sampling(sense_sampling),
        .rdata(rdata), .rvalid(rvalid), .cfg(cfg),
        .effective_dimming(effective_dimming), .temp_reading(temp_reading),
        .converter_switch(converter_switch),
        .soft_start_active(soft_start_active));

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (compares > 0 && miscompares == 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one synced frame: pin high 4 cycles, low 8
    task automatic frame;
        @(posedge clk) #1 frame_start_pin = 1'b1;
        repeat (4) @(posedge clk);
        #1 frame_start_pin = 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // watchdog beyond the longest soft-start wait
    initial begin
        #3000000;
        miscompares++;
        finish_test();
    end

    initial begin
        logic [7:0] d;
        logic prev;
        int r[$];
        int hi;
        int lows;
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        // reset values, then masked write and read back
        for (int i = 0; i < 11; i++) begin
            i_host.read_reg(8'h0e + 8'(i), d);
            check("reset", d, rstv[i]);
            i_host.write_reg(8'h0e + 8'(i), (i == 2) ? 8'h06 : 8'hff);
            i_host.read_reg(8'h0e + 8'(i), d);
            check("readback", d, expv[i]);
        end
        i_host.read_reg(8'h30, d);
        check("unmapped", d, 8'h00);
        repeat (3) @(posedge clk);
        check("extref", 8'(cfg.external_reference_select), 8'h01);
        check("sink", 8'(cfg.pixel_sink_level), 8'h07);
        check("hold", 8'(cfg.pump_hold_enable), 8'h01);
        check("shold", 8'(cfg.gamma_sense_sample_hold_enable), 8'h01);
        check("step", 8'(cfg.gamma_sense_current_step), 8'h07);
        check("isen", 8'(cfg.converter_current_sensor_enable), 8'h01);
        check("mode", 8'(cfg.cathode_regulation_mode), 8'h02);
        check("coarse", 8'(cfg.reference_current_coarse), 8'h07);
        check("div", cfg.gamma_sense_current_div, 8'h01);
        check("max_pixel_level", cfg.max_pixel_level, 8'hff);
        check("mcath", cfg.manual_cathode_level, 8'hff);
        check("fine", 8'(cfg.reference_current_fine), 8'h1f);
        check("dim", 8'(cfg.dimming_level), 8'h7f);
        check("slope", 8'(cfg.temp_slope_divider), 8'h3f);
        check("toff", cfg.temp_offset_adjust, 8'hff);
        check("dim_off", effective_dimming, 8'h00);
        i_host.write_reg(8'h10, 8'h04);
        repeat (3) @(posedge clk);
        check("dim_on", effective_dimming, 8'h7f);
        i_host.write_reg(8'h10, 8'h0d);
        repeat (3) @(posedge clk);
        check("isen_bad", 8'(cfg.converter_current_sensor_enable), 8'h00);
        check("clamped", 8'(cfg.cathode_regulation_mode), 8'h01);
        check("dim_clamp", effective_dimming, 8'h00);
        // bypassed soft-start, 125 kHz, 1:1 duty
        i_host.write_reg(8'h11, 8'hb0);
        @(posedge clk) #1 conv_start = 1'b1;
        @(posedge clk) #1 conv_start = 1'b0;
        prev = converter_switch;
        hi = 0;
        for (int c = 0; c < 700; c++) begin
            @(posedge clk) #1;
            if (converter_switch === 1'b1 && prev === 1'b0) r.push_back(c);
            if (r.size() == 1 && converter_switch === 1'b1) hi++;
            prev = converter_switch;
        end
        check("ss_byp", 8'(soft_start_active), 8'h00);
        check("rises", 8'(r.size() > 1), 8'h01);
        if (r.size() > 1) check("period", 8'(r[1] - r[0]), 8'hc8);
        check("duty", 8'(hi), 8'h64);
        // pump hold keeps the switch low while sampling
        sense_sampling = 1'b1;
        lows = 0;
        repeat (2) @(posedge clk);
        repeat (300) begin
            @(posedge clk) #1;
            lows += (converter_switch !== 1'b0);
        end
        check("pumphold", 8'(lows), 8'h00);
        sense_sampling = 1'b0;
        // soft-start of 2 ms runs when not bypassed
        i_host.write_reg(8'h11, 8'h30);
        @(posedge clk) #1 conv_start = 1'b1;
        @(posedge clk) #1 conv_start = 1'b0;
        repeat (10) @(posedge clk);
        check("ss_on", 8'(soft_start_active), 8'h01);
        repeat (49000) @(posedge clk);
        check("ss_held", 8'(soft_start_active), 8'h01);
        repeat (2000) @(posedge clk);
        check("ss_done", 8'(soft_start_active), 8'h00);
        // reading refreshed on every third frame
        i_host.write_reg(8'h16, 8'h20);
        i_host.write_reg(8'h17, 8'h05);
        i_host.write_reg(8'h18, 8'h02);
        frame();
        frame();
        check("temp_wait", temp_reading, 8'h00);
        frame();
        check("temp_new", temp_reading, 8'h45);
        i_host.read_reg(8'h19, d);
        check("temp_reg", d, 8'h45);
        finish_test();
    end
endmodule
`default_nettype wire
